// *** hw/battery_monitor_control_registers.sv ***
// Control register bank of the battery monitor front end, reached over the two-wire bus
module battery_monitor_control_registers (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic wake_pin_n_in,
  input wire logic cell_voltage_out_disable_in,
  input wire logic wake_detected_in,
  input wire logic [7:0] irq_event_in,
  input wire logic clock_halt_in,
  input wire logic [7:0] error_cond_in,
  output logic [2:0] cell_sel_out,
  output logic amp_gain_select_out,
  output logic sense_zero_out,
  output logic current_level_en_out,
  output logic [2:0] bal_switch_out,
  output logic bal_close_out,
  output logic wake_detect_run_out,
  output logic power_down_out,
  output logic int_n_out,
  output logic int_n_oe_out,
  output logic fault_n_out,
  output logic fault_n_oe_out
);
  bmon_pkg::bus_state_t state_q;
  logic [2:0] sync_s, bit_cnt_q, cell_sel_q, cur_mon_q, bal_sel_q;
  logic [7:0] shift_q, ptr_q, wr_data_q, full_byte, rd_data, scratch_q, irq_q, irq_d, err_q;
  logic wake_n_s, rw_q, wr_stb_q, rd_clr_q, wake_run_q, pd_req_q, pd_state_q;
  logic drive_lo_q, sda_oe_q;

  link_ev_if ev ();

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link event finder
  pin_sync pin_sync_i (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .raw_in({wake_pin_n_in, sda_in, scl_in}),
    .sync_out(sync_s)
  );

  link_edges link_edges_i (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .scl_s_in(sync_s[0]),
    .sda_s_in(sync_s[1]),
    .ev(ev.src)
  );

  assign wake_n_s = sync_s[2];
  assign full_byte = {shift_q[6:0], ev.sda_lvl};

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped addresses read as zero
  always_comb begin
    rd_data = bmon_pkg::RST_BYTE;
    unique case (ptr_q)
      bmon_pkg::ADDR_SCRATCH: rd_data = scratch_q;
      bmon_pkg::ADDR_CELL_SEL: rd_data = {5'h00, cell_sel_q};
      bmon_pkg::ADDR_CUR_MON: rd_data = {5'h00, cur_mon_q};
      bmon_pkg::ADDR_BAL_SW: rd_data = {5'h00, bal_sel_q};
      bmon_pkg::ADDR_POWER: rd_data = {wake_n_s, 5'h00, pd_req_q, wake_run_q};
      bmon_pkg::ADDR_IRQ: rd_data = irq_q;
      bmon_pkg::ADDR_FAULT: rd_data = err_q;
      default: rd_data = bmon_pkg::RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial bus slave: address byte, register byte, then one data byte
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= bmon_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= bmon_pkg::RST_BYTE;
      ptr_q <= bmon_pkg::RST_BYTE;
      rw_q <= bmon_pkg::DIR_WRITE;
      wr_stb_q <= 1'b0;
      wr_data_q <= bmon_pkg::RST_BYTE;
      rd_clr_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_clr_q <= 1'b0;
      if (ev.stop) begin
        state_q <= bmon_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (ev.start) begin
        state_q <= bmon_pkg::ST_ADDR;
        bit_cnt_q <= 3'h0;
        sda_oe_q <= 1'b0;
      end else if (ev.scl_rise) begin
        unique case (state_q)
          bmon_pkg::ST_ADDR, bmon_pkg::ST_REGA, bmon_pkg::ST_WDATA: begin
            shift_q <= full_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == bmon_pkg::LAST_BIT) begin
              if (state_q == bmon_pkg::ST_ADDR) begin
                // Other addresses are left alone until the next start
                if (full_byte[7:1] == bmon_pkg::DEV_ADDR) begin
                  rw_q <= full_byte[0];
                  state_q <= bmon_pkg::ST_ADDR_ACK;
                end else begin
                  state_q <= bmon_pkg::ST_IDLE;
                end
              end else if (state_q == bmon_pkg::ST_REGA) begin
                ptr_q <= full_byte;
                state_q <= bmon_pkg::ST_REGA_ACK;
              end else begin
                wr_stb_q <= 1'b1;
                wr_data_q <= full_byte;
                state_q <= bmon_pkg::ST_WDATA_ACK;
              end
            end
          end
          bmon_pkg::ST_RACK: begin
            // Master acknowledge asks for the same register again
            state_q <= ev.sda_lvl ? bmon_pkg::ST_IDLE : bmon_pkg::ST_RLOAD;
          end
          default: begin
          end
        endcase
      end else if (ev.scl_fall) begin
        unique case (state_q)
          bmon_pkg::ST_ADDR_ACK, bmon_pkg::ST_REGA_ACK, bmon_pkg::ST_WDATA_ACK: begin
            if (!sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else if (state_q == bmon_pkg::ST_ADDR_ACK && rw_q == bmon_pkg::DIR_READ) begin
              shift_q <= rd_data;
              rd_clr_q <= (ptr_q == bmon_pkg::ADDR_IRQ);
              sda_oe_q <= ~rd_data[7];
              bit_cnt_q <= 3'h0;
              state_q <= bmon_pkg::ST_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              bit_cnt_q <= 3'h0;
              // A second data byte is not acknowledged
              unique case (state_q)
                bmon_pkg::ST_ADDR_ACK: state_q <= bmon_pkg::ST_REGA;
                bmon_pkg::ST_REGA_ACK: state_q <= bmon_pkg::ST_WDATA;
                default: state_q <= bmon_pkg::ST_IDLE;
              endcase
            end
          end
          bmon_pkg::ST_RLOAD: begin
            shift_q <= rd_data;
            rd_clr_q <= (ptr_q == bmon_pkg::ADDR_IRQ);
            sda_oe_q <= ~rd_data[7];
            bit_cnt_q <= 3'h0;
            state_q <= bmon_pkg::ST_RDATA;
          end
          bmon_pkg::ST_RDATA: begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == bmon_pkg::LAST_BIT) begin
              sda_oe_q <= 1'b0;
              state_q <= bmon_pkg::ST_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b1};
              sda_oe_q <= ~shift_q[6];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Plain data registers; scratch has no side effect
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      scratch_q <= bmon_pkg::RST_BYTE;
      cur_mon_q <= 3'h0;
    end else if (wr_stb_q) begin
      if (ptr_q == bmon_pkg::ADDR_SCRATCH) begin
        scratch_q <= wr_data_q;
      end
      if (ptr_q == bmon_pkg::ADDR_CUR_MON) begin
        cur_mon_q <= wr_data_q[bmon_pkg::OUT_EN_BIT:0];
      end
    end
  end

  // Monitor-side registers are frozen while the monitor output is disabled
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cell_sel_q <= 3'h0;
      bal_sel_q <= 3'h0;
    end else if (wr_stb_q && !cell_voltage_out_disable_in) begin
      if (ptr_q == bmon_pkg::ADDR_CELL_SEL) begin
        cell_sel_q <= wr_data_q[bmon_pkg::SEL_MSB:0];
      end
      if (ptr_q == bmon_pkg::ADDR_BAL_SW) begin
        bal_sel_q <= wr_data_q[bmon_pkg::SEL_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake detect run bit; a detection beats a host write in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wake_run_q <= 1'b0;
    end else if (wake_detected_in) begin
      wake_run_q <= 1'b0;
    end else if (wr_stb_q && ptr_q == bmon_pkg::ADDR_POWER) begin
      wake_run_q <= wr_data_q[bmon_pkg::WAKE_RUN_BIT];
    end
  end

  // Power-down request and state; only the wake pin brings the device back
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pd_req_q <= 1'b0;
      pd_state_q <= 1'b0;
    end else if (pd_state_q) begin
      if (!wake_n_s) begin
        pd_state_q <= 1'b0;
        pd_req_q <= 1'b0;
      end else if (wr_stb_q && ptr_q == bmon_pkg::ADDR_POWER) begin
        pd_req_q <= wr_data_q[bmon_pkg::PD_BIT];
      end
    end else begin
      if (wr_stb_q && ptr_q == bmon_pkg::ADDR_POWER) begin
        pd_req_q <= wr_data_q[bmon_pkg::PD_BIT];
      end
      pd_state_q <= pd_req_q && wake_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests: events win over the clear-on-read; writes have no path
  always_comb begin
    irq_d = irq_q & ~{8{rd_clr_q}};
    irq_d = irq_d | irq_event_in;
    irq_d = irq_d | (clock_halt_in ? bmon_pkg::ALL_ONES : bmon_pkg::RST_BYTE);
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_q <= bmon_pkg::RST_BYTE;
      int_n_oe_out <= 1'b0;
    end else begin
      irq_q <= irq_d;
      int_n_oe_out <= |irq_d;
    end
  end

  // Error bits follow their live conditions; host writes are not decoded
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      err_q <= bmon_pkg::RST_BYTE;
      fault_n_oe_out <= 1'b0;
    end else begin
      err_q <= error_cond_in;
      fault_n_oe_out <= |error_cond_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control outputs to the analog side, all registered
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cell_sel_out <= 3'h0;
      amp_gain_select_out <= 1'b0;
      sense_zero_out <= 1'b0;
      current_level_en_out <= 1'b0;
      bal_switch_out <= 3'h0;
      bal_close_out <= 1'b0;
      wake_detect_run_out <= 1'b0;
      power_down_out <= 1'b0;
      drive_lo_q <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      cell_sel_out <= cell_sel_q;
      amp_gain_select_out <= cur_mon_q[bmon_pkg::GAIN_BIT];
      sense_zero_out <= cur_mon_q[bmon_pkg::ZERO_BIT];
      current_level_en_out <= cur_mon_q[bmon_pkg::OUT_EN_BIT] && !pd_state_q;
      bal_switch_out <= bal_sel_q;
      // One cycle of lag behind the disable edge; the analog sequencer covers it
      bal_close_out <= !cell_voltage_out_disable_in && !pd_state_q;
      // Wake detection is fed by its own run bit only, never by the amplifier setup
      wake_detect_run_out <= wake_run_q;
      power_down_out <= pd_state_q;
      drive_lo_q <= 1'b0;
      sda_oe_out <= sda_oe_q;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_out = drive_lo_q;
  assign int_n_out = drive_lo_q;
  assign fault_n_out = drive_lo_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  scratch_keep_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_stb_q && ptr_q == bmon_pkg::ADDR_SCRATCH |=> scratch_q == $past(wr_data_q))
    else $error("scratch write not stored");
  cell_lock_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cell_voltage_out_disable_in |=> $stable(cell_sel_q))
    else $error("cell select changed while monitor disabled");
  bal_lock_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cell_voltage_out_disable_in |=> $stable(bal_sel_q))
    else $error("balance select changed while monitor disabled");
  bal_open_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cell_voltage_out_disable_in |=> !bal_close_out)
    else $error("balance switch closed in disable period");
  wake_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wake_detected_in |=> !wake_run_q ##1 !wake_detect_run_out)
    else $error("wake run bit not cleared by detection");
  pd_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !pd_state_q && !wake_n_s |=> !pd_state_q)
    else $error("power-down entered while wake pin low");
  pd_exit_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    pd_state_q && wake_n_s |=> pd_state_q)
    else $error("power-down left without wake pin");
  // A fresh event one cycle later may set the pin again, so only the next cycle is checked
  irq_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rd_clr_q && irq_event_in == 8'h00 && !clock_halt_in |=> irq_q == 8'h00 && !int_n_oe_out)
    else $error("interrupt register not cleared by read");
  halt_all_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clock_halt_in |=> irq_q == 8'hFF && int_n_oe_out)
    else $error("clock halt did not set all requests");
  ov_irq_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    irq_event_in[bmon_pkg::OV_IRQ_BIT] |=> irq_q[bmon_pkg::OV_IRQ_BIT] && int_n_oe_out)
    else $error("overvoltage request not raised");
  fault_pin_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ##1 fault_n_oe_out == ($past(error_cond_in) != 8'h00) && err_q == $past(error_cond_in))
    else $error("fault pin or error register lags its conditions");
endmodule

// *** hw/bmon_pkg.sv ***
// Shared constants and types for the battery monitor control register bank
package bmon_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets, one byte address each
  localparam logic [7:0] ADDR_SCRATCH = 8'h00;
  localparam logic [7:0] ADDR_CELL_SEL = 8'h01;
  localparam logic [7:0] ADDR_CUR_MON = 8'h02;
  localparam logic [7:0] ADDR_BAL_SW = 8'h03;
  localparam logic [7:0] ADDR_POWER = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h05;
  localparam logic [7:0] ADDR_FAULT = 8'h06;

  // Serial bus device address; the value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // Direction bit of the address byte
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SEL_MSB = 2;
  localparam int GAIN_BIT = 0;
  localparam int ZERO_BIT = 1;
  localparam int OUT_EN_BIT = 2;
  localparam int WAKE_RUN_BIT = 0;
  localparam int PD_BIT = 1;
  localparam int WAKE_LVL_BIT = 7;
  localparam int OV_IRQ_BIT = 0;

  // Reset value, all-ones pattern and last bit index
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Serial bus protocol states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REGA, ST_REGA_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_RLOAD
  } bus_state_t;

endpackage

// *** hw/link_ev_if.sv ***
// Serial link events passed from the edge finder to the register bank
interface link_ev_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_lvl;

  modport src (output scl_rise, output scl_fall, output start, output stop, output sda_lvl);
  modport dst (input scl_rise, input scl_fall, input start, input stop, input sda_lvl);
endinterface

// *** hw/pin_sync.sv ***
// Two-stage synchronisers for the pins that arrive from outside the clock domain
module pin_sync (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [2:0] raw_in,
  output logic [2:0] sync_out
);
  logic [2:0] meta_q;

  ////////////////////////////////////////////////////////////////////////////////
  // One chain per pin; idle bus and wake pin rest high
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        meta_q[i] <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_q[i] <= raw_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule

// *** hw/link_edges.sv ***
// Finds clock edges and start/stop conditions on the synchronised serial link
module link_edges (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic scl_s_in,
  input wire logic sda_s_in,
  link_ev_if.src ev
);
  logic scl_prev_q;
  logic sda_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Previous levels
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s_in;
      sda_prev_q <= sda_s_in;
    end
  end

  // Events; a data change while the clock is high marks start or stop
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ev.scl_rise <= 1'b0;
      ev.scl_fall <= 1'b0;
      ev.start <= 1'b0;
      ev.stop <= 1'b0;
      ev.sda_lvl <= 1'b1;
    end else begin
      ev.scl_rise <= scl_s_in & ~scl_prev_q;
      ev.scl_fall <= ~scl_s_in & scl_prev_q;
      ev.start <= scl_s_in & scl_prev_q & sda_prev_q & ~sda_s_in;
      ev.stop <= scl_s_in & scl_prev_q & ~sda_prev_q & sda_s_in;
      ev.sda_lvl <= sda_s_in;
    end
  end
endmodule

// *** dv/host_model.sv ***
// Host model: two-wire bus master that reaches the register bank
module host_model (
  input wire logic clk_sys_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_rel_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines idle released; the clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  ////////////////////////////////////////
  // Pin changes land on the falling system edge, away from the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Start, also usable as a repeated start from a low clock
  task automatic start_c();
    sda_rel_out = 1'b1;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    sda_rel_out = 1'b0;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask

  task automatic stop_c();
    sda_rel_out = 1'b0;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    sda_rel_out = 1'b1;
    hold(8);
  endtask

  // One clock period of 80 ns; data is held the whole high phase
  task automatic bit_c(input logic b, output logic seen);
    sda_rel_out = b;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    seen = sda_line_in;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask

  // Eight bits MSB first, then the acknowledge slot; mack 1 releases it
  task automatic byte_c(input logic [7:0] b, input logic mack, output logic [7:0] got,
                        output logic ack_bit);
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], got[i]);
    end
    bit_c(mack, ack_bit);
  endtask

  // Address byte, register byte, one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] g;
    logic n0;
    logic n1;
    logic n2;
    start_c();
    byte_c({bmon_pkg::DEV_ADDR, bmon_pkg::DIR_WRITE}, 1'b1, g, n0);
    byte_c(a, 1'b1, g, n1);
    byte_c(d, 1'b1, g, n2);
    stop_c();
    ok = !(n0 | n1 | n2);
  endtask

  // Pointer write, repeated start, one byte read and closed by a no-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] g;
    logic n;
    start_c();
    byte_c({bmon_pkg::DEV_ADDR, bmon_pkg::DIR_WRITE}, 1'b1, g, n);
    byte_c(a, 1'b1, g, n);
    start_c();
    byte_c({bmon_pkg::DEV_ADDR, bmon_pkg::DIR_READ}, 1'b1, g, n);
    byte_c(8'hFF, 1'b1, d, n);
    stop_c();
  endtask
endmodule

// *** dv/battery_monitor_control_registers_test.sv ***
// Self-checking bench for the battery monitor control register bank
module battery_monitor_control_registers_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic wake_pin_n_in = 1'b1;
  logic cell_voltage_out_disable_in = 1'b0;
  logic wake_detected_in = 1'b0;
  logic [7:0] irq_event_in = 8'h00;
  logic clock_halt_in = 1'b0;
  logic [7:0] error_cond_in = 8'h00;
  logic scl, sda_rel, sda_line, sda_out, sda_oe_out;
  logic [2:0] cell_sel_out, bal_switch_out;
  logic amp_gain_select_out, sense_zero_out, current_level_en_out, bal_close_out;
  logic wake_detect_run_out, power_down_out, int_n_out, int_n_oe_out;
  logic fault_n_out, fault_n_oe_out;
  int failures = 0;
  int checked = 0;
  logic [7:0] rd;
  logic [7:0] junk;
  logic ok;
  logic nk;
  logic [7:0] amp_bits;

  // Pulled-up data wire: low when either party pulls it
  assign sda_line = sda_rel & ~(sda_oe_out & ~sda_out);

  // Current monitor controls in register bit order
  assign amp_bits = {5'h00, current_level_en_out, sense_zero_out, amp_gain_select_out};

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  battery_monitor_control_registers battery_monitor_control_registers_i (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wake_pin_n_in(wake_pin_n_in),
    .cell_voltage_out_disable_in(cell_voltage_out_disable_in), .wake_detected_in(wake_detected_in),
    .irq_event_in(irq_event_in), .clock_halt_in(clock_halt_in),
    .error_cond_in(error_cond_in), .cell_sel_out(cell_sel_out),
    .amp_gain_select_out(amp_gain_select_out), .sense_zero_out(sense_zero_out),
    .current_level_en_out(current_level_en_out), .bal_switch_out(bal_switch_out),
    .bal_close_out(bal_close_out), .wake_detect_run_out(wake_detect_run_out),
    .power_down_out(power_down_out), .int_n_out(int_n_out), .int_n_oe_out(int_n_oe_out),
    .fault_n_out(fault_n_out), .fault_n_oe_out(fault_n_oe_out));

  host_model host_model_i (.clk_sys_in(clk_sys_in), .sda_line_in(sda_line),
    .scl_out(scl), .sda_rel_out(sda_rel));

  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_i.write_reg(a, d, ok);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.read_reg(a, rd);
    chk(rd, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is near 24k cycles; close to four times that means a hang
  initial begin
    #450000;
    failures++;
    wrap_up();
  end

  ////////////////////////////////////////
  initial begin
    tick(6);
    srst_in = 1'b0;
    tick(4);
    // Reset state; only the wake level bit reads high
    for (int a = 0; a < 7; a++) begin
      rd_chk(8'(a), (a == 4) ? 8'h80 : 8'h00);
    end
    wr(8'h00, 8'hA5);
    chk({7'h00, ok}, 8'h01);
    rd_chk(8'h00, 8'hA5);
    chk({cell_sel_out, bal_switch_out, bal_close_out, power_down_out}, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, 8'(i));
      chk({5'h00, cell_sel_out}, 8'(i));
    end
    // Open all switches before choosing a new one
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h05);
    chk({4'h0, bal_close_out, bal_switch_out}, 8'h0D);
    // Disable period: switches open, both selects frozen
    cell_voltage_out_disable_in = 1'b1;
    tick(3);
    chk({7'h00, bal_close_out}, 8'h00);
    wr(8'h01, 8'h02);
    chk({5'h00, cell_sel_out}, 8'h07);
    wr(8'h03, 8'h00);
    rd_chk(8'h03, 8'h05);
    cell_voltage_out_disable_in = 1'b0;
    tick(3);
    chk({4'h0, bal_close_out, bal_switch_out}, 8'h0D);
    // Gain, zeroing and output enable; zeroing only with output on
    for (int i = 0; i < 8; i++) begin
      if (i == 2 || i == 3) continue;
      wr(8'h02, 8'(i));
      chk(amp_bits, 8'(i));
    end
    // Wake detector start, self-clear with the monitor register fully set
    wr(8'h04, 8'h01);
    chk({7'h00, wake_detect_run_out}, 8'h01);
    wake_detected_in = 1'b1;
    tick(1);
    wake_detected_in = 1'b0;
    tick(2);
    chk({7'h00, wake_detect_run_out}, 8'h00);
    rd_chk(8'h04, 8'h80);
    // Power-down requested while the wake pin is low waits for it to rise
    wake_pin_n_in = 1'b0;
    tick(6);
    rd_chk(8'h04, 8'h00);
    wr(8'h04, 8'h02);
    tick(20);
    chk({7'h00, power_down_out}, 8'h00);
    wake_pin_n_in = 1'b1;
    tick(10);
    chk({5'h00, power_down_out, current_level_en_out, bal_close_out}, 8'h04);
    wr(8'h04, 8'h00);
    tick(10);
    chk({7'h00, power_down_out}, 8'h01);
    wake_pin_n_in = 1'b0;
    tick(10);
    chk({7'h00, power_down_out}, 8'h00);
    wake_pin_n_in = 1'b1;
    tick(6);
    rd_chk(8'h04, 8'h80);
    // Overvoltage request, clear on read
    irq_event_in = 8'h01;
    tick(1);
    irq_event_in = 8'h00;
    tick(2);
    chk({7'h00, int_n_oe_out}, 8'h01);
    rd_chk(8'h05, 8'h01);
    tick(4);
    chk({7'h00, int_n_oe_out}, 8'h00);
    clock_halt_in = 1'b1;
    tick(1);
    clock_halt_in = 1'b0;
    rd_chk(8'h05, 8'hFF);
    wr(8'h05, 8'hFF);
    rd_chk(8'h05, 8'h00);
    // Error mirror and fault pin
    error_cond_in = 8'h12;
    tick(2);
    chk({7'h00, fault_n_oe_out}, 8'h01);
    chk({6'h00, int_n_out, fault_n_out}, 8'h00);
    wr(8'h06, 8'h00);
    rd_chk(8'h06, 8'h12);
    error_cond_in = 8'h00;
    tick(2);
    chk({7'h00, fault_n_oe_out}, 8'h00);
    rd_chk(8'h06, 8'h00);
    // Foreign device address gets no acknowledge
    host_model_i.start_c();
    host_model_i.byte_c({~bmon_pkg::DEV_ADDR, 1'b0}, 1'b1, junk, nk);
    host_model_i.stop_c();
    chk({7'h00, nk}, 8'h01);
    // A second data byte is refused and leaves the first in place
    host_model_i.start_c();
    host_model_i.byte_c({bmon_pkg::DEV_ADDR, 1'b0}, 1'b1, junk, nk);
    host_model_i.byte_c(8'h00, 1'b1, junk, nk);
    host_model_i.byte_c(8'h3C, 1'b1, junk, nk);
    host_model_i.byte_c(8'hC3, 1'b1, junk, nk);
    host_model_i.stop_c();
    chk({7'h00, nk}, 8'h01);
    rd_chk(8'h00, 8'h3C);
    // Master acknowledge after the first byte asks for the same register again
    host_model_i.start_c();
    host_model_i.byte_c({bmon_pkg::DEV_ADDR, bmon_pkg::DIR_WRITE}, 1'b1, junk, nk);
    host_model_i.byte_c(8'h00, 1'b1, junk, nk);
    host_model_i.start_c();
    host_model_i.byte_c({bmon_pkg::DEV_ADDR, bmon_pkg::DIR_READ}, 1'b1, junk, nk);
    host_model_i.byte_c(8'hFF, 1'b0, rd, nk);
    host_model_i.byte_c(8'hFF, 1'b1, junk, nk);
    host_model_i.stop_c();
    chk(rd, 8'h3C);
    chk(junk, 8'h3C);
    rd_chk(8'h10, 8'h00);
    wrap_up();
  end
endmodule
